/* File: common/instr_pkg.sv */
// Purpose: shared constants for the call, i/o and status decoder
// Assumes: 8-bit opcodes, three clocks per processor cycle
// Notes: opcode groups keep the register field in bits 1:0
package instr_pkg;
  // ==========================================================
  // opcodes and group bases
  localparam logic [7:0] OP_ZCALL = 8'hbb;
  localparam logic [7:0] OP_XCALL = 8'hbf;
  localparam logic [7:0] OP_RET = 8'h14;
  localparam logic [7:0] OP_RETE = 8'h34;
  localparam logic [7:0] OP_READ_EXTENDED_PORT = 8'h54;
  localparam logic [7:0] OP_WRITE_EXTENDED_PORT = 8'hd4;
  localparam logic [7:0] OP_READ_CONTROL_PORT = 8'h30;
  localparam logic [7:0] OP_WRITE_DATA_PORT = 8'hf0;
  localparam logic [7:0] OP_READ_DATA_PORT = 8'h70;
  localparam logic [7:0] OP_HALT = 8'h40;
  localparam logic [7:0] OP_TMI = 8'hf4;
  localparam logic [7:0] OP_LOAD_LOWER_STATUS_FROM_MEMORY = 8'h10;
  localparam logic [7:0] OP_STORE_LOWER_STATUS_TO_MEMORY = 8'h11;
  localparam logic [7:0] OP_CPSU = 8'h74;
  localparam logic [7:0] OP_CPSL = 8'h75;
  localparam logic [7:0] OP_PPSU = 8'h76;
  localparam logic [7:0] OP_PPSL = 8'h77;
  localparam logic [7:0] OP_TPSU = 8'hb4;
  localparam logic [7:0] OP_TPSL = 8'hb5;
  localparam logic [7:0] OP_LPSU = 8'h92;
  localparam logic [7:0] GROUP_MASK = 8'hfc;
  // ==========================================================
  // condition codes
  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_POS = 2'h1;
  localparam logic [1:0] CC_NEG = 2'h2;
  localparam logic [1:0] CC_ALWAYS = 2'h3;
  // ==========================================================
  // status word fields (upper: sp 2:0, uf 4:3, ii 5; lower)
  localparam int SP_LSB = 0;
  localparam int UF_LSB = 3;
  localparam int II_BIT = 5;
  localparam int CC_LSB = 6;
  localparam int RS_BIT = 4;
  localparam int WC_BIT = 3;
  localparam int COM_BIT = 1;
  localparam logic [7:0] UPPER_RST = 8'h00;
  localparam logic [7:0] LOWER_RST = 8'h00;
  localparam logic [7:0] UF_MASK = 8'h18;
  // ==========================================================
  // timing
  localparam logic [1:0] CLK_PER_CYC = 2'h3;
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;
  localparam logic [2:0] CYC_IND = 3'h2;
  localparam int STACK_DEPTH = 8;
  typedef enum logic [3:0] {
    K_NONE, K_ZCALL, K_XCALL, K_RET, K_READ_EXTENDED_PORT, K_WRITE_EXTENDED_PORT, K_READ_CONTROL_PORT,
    K_WRITE_DATA_PORT, K_READ_DATA_PORT, K_HALT, K_TMI, K_LOAD_LOWER_STATUS_FROM_MEMORY, K_STORE_LOWER_STATUS_TO_MEMORY, K_PSMOD,
    K_TPS, K_LPSU
  } kind_t;
endpackage

/* File: hw/cycle_timer.sv */
// Purpose: counts processor cycles of three clocks each
// Assumes: start pulses only while idle
// Notes: done pulses in the last clock of the last cycle
module cycle_timer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [2:0] cycles,
  output logic busy,
  output logic done
);
  logic [1:0] phase_ff;
  logic [2:0] left_ff;
  logic busy_ff;
  wire last_phase = (phase_ff == instr_pkg::CLK_PER_CYC - 2'h1);
  assign busy = busy_ff;
  assign done = busy_ff && last_phase && (left_ff == 3'h1);
  // each processor cycle is three clock periods
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= 2'h0;
      left_ff <= 3'h0;
      busy_ff <= 1'b0;
    end else if (start && !busy_ff) begin
      phase_ff <= 2'h0;
      left_ff <= cycles;
      busy_ff <= 1'b1;
    end else if (busy_ff) begin
      phase_ff <= last_phase ? 2'h0 : phase_ff + 2'h1;
      if (last_phase) begin
        left_ff <= left_ff - 3'h1;
        if (left_ff == 3'h1) begin
          busy_ff <= 1'b0;
        end
      end
    end
  end
endmodule

/* File: hw/call_io_status_decode.sv */
// Purpose: decode and sequence call, return, i/o, halt and status ops
// Assumes: instruction bytes arrive whole on instr_valid; bus data
//   arrives with the issue; stack held here
// Notes: one processor cycle is three sys_clk periods
//
// Functional notes
// - BB zero page call, 2 bytes, 3(+2)
// - BF indexed call, 3 bytes, 3 cycles, r3
// - returns 14-17 and 34-37, one byte, 3 cycles
// - extended read: port byte, set cc
// - extended write: register onto bus, port
// - control read loads register, sets cc
// - data write outputs register, cc kept
// - data read loads register, sets cc
// - 40 halts into wait state
// - F4-F7 mask test, cc only
// - mask test cc 00 all ones, else 10
// - load lower status from memory, 4 cycles
// - store lower status, 4 cycles, +2 indirect
// - 74/75 masked clear of status bytes
// - 76/77 masked preset of status bytes
// - B4/B5 masked status test via cc
// - 92 loads upper status from r0
// - cc 01 positive, 00 zero, 10 negative
// - indirect memory operand adds two cycles
// - conditional indirect adds two when taken
// - condition 11 is always true
// - processor cycle is three clock periods
// - interrupt: finish, inhibit, vectored call, ack
module call_io_status_decode (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic [14:0] next_pc,
  input wire logic enhanced_variant,
  input wire logic [7:0] reg_r0,
  input wire logic [7:0] reg_sel_val,
  input wire logic [7:0] reg_r3,
  input wire logic [7:0] bus_data_in,
  input wire logic [7:0] mem_data_in,
  input wire logic int_request,
  output logic instr_ready,
  output logic busy,
  output logic [1:0] bytes_used,
  output logic [2:0] cycles_used,
  output logic halted,
  output logic [14:0] jump_addr,
  output logic jump_valid,
  output logic [7:0] port_addr,
  output logic port_ext,
  output logic port_write,
  output logic port_read,
  output logic port_is_data,
  output logic [7:0] bus_data_out,
  output logic [14:0] mem_addr,
  output logic mem_write,
  output logic [7:0] reg_wr_data,
  output logic [1:0] reg_wr_sel,
  output logic reg_wr_en,
  output logic interrupt_acknowledge,
  output logic [7:0] upper_status_byte,
  output logic [7:0] lower_status_byte
);
  typedef enum logic [1:0] {
    ST_IDLE, ST_EXEC, ST_HALT
  } state_t;
  state_t state_ff;
  instr_pkg::kind_t kind;
  logic [7:0] psu_ff, psl_ff, nxt_psu, nxt_psl;
  logic [14:0] stack_ff [instr_pkg::STACK_DEPTH];
  logic [14:0] jump_addr_ff, mem_addr_ff;
  logic [7:0] port_addr_ff, bus_out_ff, reg_wr_data_ff;
  logic [1:0] bytes_ff, reg_wr_sel_ff;
  logic [2:0] cycles_ff;
  logic jump_valid_ff, port_ext_ff, port_wr_ff, port_rd_ff;
  logic port_data_ff, mem_wr_ff, reg_wr_en_ff, ack_ff;
  logic timer_busy, timer_done;
  // ==========================================================
  // opcode decode
  wire [7:0] grp = opcode & instr_pkg::GROUP_MASK;
  wire [1:0] rfld = opcode[1:0];
  wire indirect = operand1[7];
  always_comb begin
    kind = instr_pkg::K_NONE;
    if (opcode == instr_pkg::OP_ZCALL) kind = instr_pkg::K_ZCALL;
    else if (opcode == instr_pkg::OP_XCALL)
      kind = instr_pkg::K_XCALL;
    else if (grp == instr_pkg::OP_RET || grp == instr_pkg::OP_RETE)
      kind = instr_pkg::K_RET;
    else if (grp == instr_pkg::OP_READ_EXTENDED_PORT) kind = instr_pkg::K_READ_EXTENDED_PORT;
    else if (grp == instr_pkg::OP_WRITE_EXTENDED_PORT) kind = instr_pkg::K_WRITE_EXTENDED_PORT;
    else if (grp == instr_pkg::OP_READ_CONTROL_PORT) kind = instr_pkg::K_READ_CONTROL_PORT;
    else if (grp == instr_pkg::OP_WRITE_DATA_PORT) kind = instr_pkg::K_WRITE_DATA_PORT;
    else if (grp == instr_pkg::OP_READ_DATA_PORT) kind = instr_pkg::K_READ_DATA_PORT;
    else if (opcode == instr_pkg::OP_HALT) kind = instr_pkg::K_HALT;
    else if (grp == instr_pkg::OP_TMI) kind = instr_pkg::K_TMI;
    else if (opcode == instr_pkg::OP_LOAD_LOWER_STATUS_FROM_MEMORY && enhanced_variant)
      kind = instr_pkg::K_LOAD_LOWER_STATUS_FROM_MEMORY;
    else if (opcode == instr_pkg::OP_STORE_LOWER_STATUS_TO_MEMORY && enhanced_variant)
      kind = instr_pkg::K_STORE_LOWER_STATUS_TO_MEMORY;
    else if (grp == instr_pkg::OP_CPSU) kind = instr_pkg::K_PSMOD;
    else if (opcode == instr_pkg::OP_TPSU || opcode == instr_pkg::OP_TPSL)
      kind = instr_pkg::K_TPS;
    else if (opcode == instr_pkg::OP_LPSU) kind = instr_pkg::K_LPSU;
  end
  // ==========================================================
  // conditions and condition codes
  wire [1:0] cc_now = psl_ff[instr_pkg::CC_LSB +: 2];
  wire cond_true = (rfld == instr_pkg::CC_ALWAYS) || (rfld == cc_now);
  wire take_int = int_request && !psu_ff[instr_pkg::II_BIT];
  function automatic logic [1:0] sign_cc(input logic [7:0] v);
    if (v == 8'h00) sign_cc = instr_pkg::CC_ZERO;
    else if (v[7]) sign_cc = instr_pkg::CC_NEG;
    else sign_cc = instr_pkg::CC_POS;
  endfunction
  function automatic logic [1:0] mask_cc(input logic [7:0] v,
                                        input logic [7:0] m);
    mask_cc = ((v & m) == m) ? instr_pkg::CC_ZERO : instr_pkg::CC_NEG;
  endfunction
  wire [7:0] tps_src = opcode[0] ? psl_ff : psu_ff;
  wire [2:0] sp = psu_ff[instr_pkg::SP_LSB +: 3];
  wire [2:0] sp_up = sp + 3'h1;
  wire [2:0] sp_dn = sp - 3'h1;
  wire [14:0] rel_tgt = {8'h00, operand1[6:0]}; // page zero offset
  wire [14:0] abs_tgt = {operand1[6:0], operand2} + {7'h00, reg_r3};
  wire [7:0] uf_keep = enhanced_variant ? instr_pkg::UF_MASK : 8'h00;
  // ==========================================================
  // byte and cycle figures per kind
  logic [1:0] nbytes;
  logic [2:0] ncyc;
  always_comb begin
    nbytes = 2'h1;
    ncyc = instr_pkg::CYC_2;
    case (kind)
      instr_pkg::K_ZCALL: begin
        nbytes = 2'h2;
        ncyc = instr_pkg::CYC_3 + (indirect ? instr_pkg::CYC_IND : 3'h0);
      end
      instr_pkg::K_XCALL: begin
        nbytes = 2'h3;
        ncyc = instr_pkg::CYC_3;
      end
      instr_pkg::K_RET: ncyc = instr_pkg::CYC_3;
      instr_pkg::K_HALT: ncyc = instr_pkg::CYC_1;
      instr_pkg::K_LOAD_LOWER_STATUS_FROM_MEMORY, instr_pkg::K_STORE_LOWER_STATUS_TO_MEMORY: begin
        nbytes = 2'h3;
        ncyc = instr_pkg::CYC_4 + (indirect ? instr_pkg::CYC_IND : 3'h0);
      end
      instr_pkg::K_READ_EXTENDED_PORT, instr_pkg::K_WRITE_EXTENDED_PORT, instr_pkg::K_TMI,
      instr_pkg::K_PSMOD, instr_pkg::K_TPS: begin
        nbytes = 2'h2;
        ncyc = instr_pkg::CYC_3;
      end
      default: ;
    endcase
    if (take_int) begin
      nbytes = 2'h2;
      ncyc = instr_pkg::CYC_3 + (bus_data_in[7] ? instr_pkg::CYC_IND : 3'h0);
    end // interrupt call is taken, so indirect adds
  end
  // ==========================================================
  // status word next values
  always_comb begin
    nxt_psu = psu_ff;
    nxt_psl = psl_ff;
    case (kind)
      instr_pkg::K_ZCALL, instr_pkg::K_XCALL:
        nxt_psu[instr_pkg::SP_LSB +: 3] = sp_up;
      instr_pkg::K_RET: if (cond_true) begin
        nxt_psu[instr_pkg::SP_LSB +: 3] = sp_dn;
        if (opcode[5]) nxt_psu[instr_pkg::II_BIT] = 1'b0;
      end
      instr_pkg::K_READ_EXTENDED_PORT, instr_pkg::K_READ_CONTROL_PORT, instr_pkg::K_READ_DATA_PORT:
        nxt_psl[instr_pkg::CC_LSB +: 2] = sign_cc(bus_data_in);
      instr_pkg::K_TMI:
        nxt_psl[instr_pkg::CC_LSB +: 2] = mask_cc(reg_sel_val, operand1);
      instr_pkg::K_LOAD_LOWER_STATUS_FROM_MEMORY: nxt_psl = mem_data_in;
      instr_pkg::K_PSMOD: begin
        if (opcode[1]) begin
          if (opcode[0]) nxt_psl = psl_ff | operand1;
          else nxt_psu = psu_ff | (operand1 & ~(~uf_keep & instr_pkg::UF_MASK));
        end else begin
          if (opcode[0]) nxt_psl = psl_ff & ~operand1;
          else nxt_psu = psu_ff & ~operand1;
        end
      end
      instr_pkg::K_TPS:
        nxt_psl[instr_pkg::CC_LSB +: 2] = mask_cc(tps_src, operand1);
      instr_pkg::K_LPSU:
        nxt_psu = (reg_r0 & ~instr_pkg::UF_MASK) | (reg_r0 & uf_keep);
      default: ;
    endcase
    if (take_int) begin
      nxt_psl = psl_ff; // pending opcode must not touch lower status
      nxt_psu = psu_ff;
      nxt_psu[instr_pkg::II_BIT] = 1'b1;
      nxt_psu[instr_pkg::SP_LSB +: 3] = sp_up;
    end
  end
  // ==========================================================
  // sequencing
  // only an interrupt leaves the wait state; a request there is refused
  wire idle_now = (state_ff == ST_IDLE);
  wire wake_ok = idle_now || (state_ff == ST_HALT);
  wire issue = !timer_busy
             && ((idle_now && instr_valid) || (wake_ok && take_int));
  cycle_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(issue),
    .cycles(ncyc),
    .busy(timer_busy),
    .done(timer_done)
  );
  assign instr_ready = (state_ff == ST_IDLE) && !timer_busy && !take_int;
  assign busy = timer_busy;
  assign halted = (state_ff == ST_HALT);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else if (issue && !take_int && kind == instr_pkg::K_HALT) begin
      state_ff <= ST_HALT;
    end else if (issue) begin
      state_ff <= ST_EXEC;
    end else if (timer_done && state_ff == ST_EXEC) begin
      state_ff <= ST_IDLE;
    end
  end
  // status registers, updated when an instruction issues
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      psu_ff <= instr_pkg::UPPER_RST;
      psl_ff <= instr_pkg::LOWER_RST;
    end else if (issue) begin
      psu_ff <= nxt_psu;
      psl_ff <= nxt_psl;
    end
  end
  // return address stack
  wire push = issue && (take_int || kind == instr_pkg::K_ZCALL
                        || kind == instr_pkg::K_XCALL);
  genvar gi;
  for (gi = 0; gi < instr_pkg::STACK_DEPTH; gi++) begin : g_stack
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) stack_ff[gi] <= 15'h0000;
      else if (push && sp == 3'(gi)) stack_ff[gi] <= next_pc;
    end
  end
  // ==========================================================
  // bus side outputs, held from issue until the next issue
  wire is_call = take_int || kind == instr_pkg::K_ZCALL;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      jump_addr_ff <= 15'h0000;
      jump_valid_ff <= 1'b0;
      port_addr_ff <= 8'h00;
      port_ext_ff <= 1'b0;
      port_wr_ff <= 1'b0;
      port_rd_ff <= 1'b0;
      port_data_ff <= 1'b0;
      bus_out_ff <= 8'h00;
      mem_addr_ff <= 15'h0000;
      mem_wr_ff <= 1'b0;
      reg_wr_data_ff <= 8'h00;
      reg_wr_sel_ff <= 2'h0;
      reg_wr_en_ff <= 1'b0;
      ack_ff <= 1'b0;
      bytes_ff <= 2'h0;
      cycles_ff <= 3'h0;
    end else if (issue) begin
      bytes_ff <= nbytes;
      cycles_ff <= ncyc;
      ack_ff <= take_int;
      jump_valid_ff <= !take_int ?
        (kind == instr_pkg::K_ZCALL || kind == instr_pkg::K_XCALL
         || (kind == instr_pkg::K_RET && cond_true)) : 1'b1;
      jump_addr_ff <= take_int ? {8'h00, bus_data_in[6:0]} :
        is_call ? rel_tgt :
        kind == instr_pkg::K_XCALL ? abs_tgt : stack_ff[sp_dn];
      port_addr_ff <= operand1;
      port_ext_ff <= !take_int && (kind == instr_pkg::K_READ_EXTENDED_PORT
                                   || kind == instr_pkg::K_WRITE_EXTENDED_PORT);
      port_wr_ff <= !take_int && (kind == instr_pkg::K_WRITE_EXTENDED_PORT
                                  || kind == instr_pkg::K_WRITE_DATA_PORT);
      port_rd_ff <= !take_int && (kind == instr_pkg::K_READ_EXTENDED_PORT
        || kind == instr_pkg::K_READ_CONTROL_PORT || kind == instr_pkg::K_READ_DATA_PORT);
      port_data_ff <= kind == instr_pkg::K_WRITE_DATA_PORT
                   || kind == instr_pkg::K_READ_DATA_PORT;
      bus_out_ff <= kind == instr_pkg::K_STORE_LOWER_STATUS_TO_MEMORY ? psl_ff : reg_sel_val;
      mem_addr_ff <= {operand1[6:0], operand2};
      mem_wr_ff <= !take_int && kind == instr_pkg::K_STORE_LOWER_STATUS_TO_MEMORY;
      reg_wr_data_ff <= bus_data_in;
      reg_wr_sel_ff <= rfld;
      reg_wr_en_ff <= port_rd_ff_next(kind, take_int);
    end
  end
  function automatic logic port_rd_ff_next(input instr_pkg::kind_t k,
                                           input logic ti);
    port_rd_ff_next = !ti && (k == instr_pkg::K_READ_EXTENDED_PORT
      || k == instr_pkg::K_READ_CONTROL_PORT || k == instr_pkg::K_READ_DATA_PORT);
  endfunction
  assign bytes_used = bytes_ff;
  assign cycles_used = cycles_ff;
  assign jump_addr = jump_addr_ff;
  assign jump_valid = jump_valid_ff;
  assign port_addr = port_addr_ff;
  assign port_ext = port_ext_ff;
  assign port_write = port_wr_ff;
  assign port_read = port_rd_ff;
  assign port_is_data = port_data_ff;
  assign bus_data_out = bus_out_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_write = mem_wr_ff;
  assign reg_wr_data = reg_wr_data_ff;
  assign reg_wr_sel = reg_wr_sel_ff;
  assign reg_wr_en = reg_wr_en_ff;
  assign interrupt_acknowledge = ack_ff;
  assign upper_status_byte = psu_ff;
  assign lower_status_byte = psl_ff;
endmodule

/* File: bench/decode_checker.sv */
// Purpose: temporal checks on the call, i/o and status decoder ports
// Assumes: one clock domain, async active-low reset
// Notes: operands are captured at issue so results tie to causes
module decode_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] reg_sel_val,
  input wire logic [7:0] bus_data_in,
  input wire logic instr_ready,
  input wire logic busy,
  input wire logic [2:0] cycles_used,
  input wire logic halted,
  input wire logic [14:0] jump_addr,
  input wire logic jump_valid,
  input wire logic port_write,
  input wire logic port_is_data,
  input wire logic [7:0] bus_data_out,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic [7:0] lower_status_byte
);
  // ==========================================================
  // issue capture
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic iss_ff;
  logic [4:0] run_ff;
  logic [7:0] op_ff, m_ff, sel_ff, bus_ff, lo_ff;
  wire logic iss = instr_valid && instr_ready;
  wire logic [7:0] grp = op_ff & instr_pkg::GROUP_MASK;
  wire logic [1:0] mcc = ((sel_ff & m_ff) == m_ff) ? 2'h0 : 2'h2;
  wire logic [1:0] scc = (bus_ff == 8'h00) ? 2'h0 : {bus_ff[7], !bus_ff[7]};
  // length of the current busy run
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      iss_ff <= 1'b0;
      run_ff <= 5'h00;
    end else begin
      iss_ff <= iss;
      run_ff <= busy ? run_ff + 5'h01 : 5'h00;
    end
  end
  // operands and prior status seen at the issuing edge
  always_ff @(posedge sys_clk) begin
    if (iss) begin
      op_ff <= opcode;
      m_ff <= operand1;
      sel_ff <= reg_sel_val;
      bus_ff <= bus_data_in;
      lo_ff <= lower_status_byte;
    end
  end
  // ==========================================================
  // assertions
  ready_vs_busy_a: assert property (busy |-> !instr_ready)
    else $error("ready while busy");
  busy_length_a: assert property (
    $fell(busy) |-> run_ff == 5'(cycles_used) * 5'h03)
    else $error("busy run differs from three clocks per cycle");
  mask_test_a: assert property (
    iss_ff && grp == instr_pkg::OP_TMI |-> lower_status_byte[7:6] == mcc)
    else $error("mask test condition wrong");
  halt_wait_a: assert property (
    iss_ff && op_ff == instr_pkg::OP_HALT |-> halted && cycles_used == 3'h1)
    else $error("halt did not wait");
  data_write_a: assert property (iss_ff && grp == instr_pkg::OP_WRITE_DATA_PORT |->
    port_write && port_is_data && bus_data_out == sel_ff
    && lower_status_byte[7:6] == lo_ff[7:6]) else $error("data write wrong");
  data_read_a: assert property (iss_ff && grp == instr_pkg::OP_READ_DATA_PORT |->
    reg_wr_en && reg_wr_data == bus_ff && lower_status_byte[7:6] == scc)
    else $error("data read wrong");
  preset_low_a: assert property (iss_ff && op_ff == instr_pkg::OP_PPSL |->
    lower_status_byte == (lo_ff | m_ff)) else $error("preset wrong");
  zero_call_a: assert property (iss_ff && op_ff == instr_pkg::OP_ZCALL |->
    jump_valid && jump_addr == {8'h00, m_ff[6:0]}
    && cycles_used == (m_ff[7] ? 3'h5 : 3'h3)) else $error("call wrong");
  cover property (iss && opcode == instr_pkg::OP_HALT);
  cover property ($fell(busy) && cycles_used == 3'h6);
  cover property (iss_ff && jump_valid);
endmodule

bind call_io_status_decode decode_checker chk (.*);

/* File: bench/io_model.sv */
// Purpose: memory and i/o bus stand-in feeding data to the decoder
// Assumes: the bench raises present while a read or vector is due
// Notes: otherwise the lines show a pattern that moves every clock
module io_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic present,
  input wire logic [7:0] value,
  output logic [7:0] bus_data_in,
  output logic [7:0] mem_data_in
);
  // ==========================================================
  // bus drive
  logic [7:0] junk_ff;
  // undriven bus wanders so stale data never looks valid
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      junk_ff <= 8'h5a;
    end else begin
      junk_ff <= junk_ff + 8'h3b;
    end
  end
  // port data, interrupt vector and memory byte
  assign bus_data_in = present ? value : junk_ff;
  assign mem_data_in = present ? value : ~junk_ff;
endmodule

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for the call, i/o and status decoder
// Assumes: inputs change 1 ns after the rising edge
// Notes: random data from a bench shift register, fixed start
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  logic sys_clk, rst_n, instr_valid, enhanced_variant, int_request, present;
  logic [7:0] opcode, operand1, operand2, reg_r0, reg_sel_val, reg_r3;
  logic [7:0] bus_data_in, mem_data_in, port_addr, bus_data_out, value;
  logic [7:0] reg_wr_data, upper_status_byte, lower_status_byte, a, b, lo, op;
  logic [14:0] next_pc, jump_addr, mem_addr;
  logic [1:0] bytes_used, reg_wr_sel;
  logic [2:0] cycles_used;
  logic instr_ready, busy, halted, jump_valid, port_ext, port_write;
  logic port_read, port_is_data, mem_write, reg_wr_en, interrupt_acknowledge;
  logic [15:0] lf;
  int err_count, checked, cyc;
  call_io_status_decode dut (.*);
  io_model partner (.*);
  // ==========================================================
  // helpers
  function automatic logic [1:0] mcc(input logic [7:0] v, m);
    return ((v & m) == m) ? instr_pkg::CC_ZERO : instr_pkg::CC_NEG;
  endfunction
  function automatic logic [1:0] scc(input logic [7:0] v);
    if (v == 8'h00) return instr_pkg::CC_ZERO;
    return v[7] ? instr_pkg::CC_NEG : instr_pkg::CC_POS;
  endfunction
  task automatic rnd(output logic [7:0] v);
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    v = lf[7:0];
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("err_count=%0d checked=%0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // issue one instruction, hold it until taken, wait out busy
  task automatic run(input logic [7:0] o, o1, o2);
    int n;
    opcode = o;
    operand1 = o1;
    operand2 = o2;
    instr_valid = 1'b1;
    for (n = 0; n < 50 && instr_ready !== 1'b1; n++) @(posedge sys_clk) #1;
    @(posedge sys_clk) #1;
    instr_valid = 1'b0;
    for (n = 0; n < 50 && busy === 1'b1; n++) @(posedge sys_clk) #1;
  endtask
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    {rst_n, instr_valid, enhanced_variant, int_request, present} = 5'h00;
    {opcode, operand1, operand2, reg_r0, reg_sel_val, reg_r3} = 48'h0;
    {value, next_pc} = 23'h0;
    lf = 16'h2fa9;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rnd(a);
      rnd(b);
      if (i == 0) b = 8'h00;
      if (i == 1) a = 8'hff;
      reg_sel_val = a;
      lo = lower_status_byte;
      run(instr_pkg::OP_TMI | 8'(i % 4), b, 8'h00);
      cmp(lower_status_byte[7:6], mcc(a, b));
      cmp({lower_status_byte[5:0], bytes_used, cycles_used}, {lo[5:0], 5'h13});
    end
    for (int i = 0; i < 4; i++) begin
      lo = lower_status_byte;
      rnd(b);
      run(instr_pkg::OP_PPSL, b, 8'h00);
      cmp(lower_status_byte, lo | b);
      lo = lower_status_byte;
      rnd(b);
      run(instr_pkg::OP_CPSL, b, 8'h00);
      cmp({lower_status_byte, bytes_used, cycles_used}, {lo & ~b, 5'h13});
    end
    run(instr_pkg::OP_PPSL, 8'h18, 8'h00);
    run(instr_pkg::OP_TPSL, 8'h18, 8'h00);
    cmp(lower_status_byte[7:6], 2'h0);
    run(instr_pkg::OP_CPSL, 8'h08, 8'h00);
    run(instr_pkg::OP_TPSL, 8'h18, 8'h00);
    cmp(lower_status_byte[7:6], 2'h2);
    present = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rnd(a);
      rnd(b);
      if (i < 2) a = i ? 8'h80 : 8'h00;
      value = a;
      op = (i % 3 == 0) ? instr_pkg::OP_READ_DATA_PORT : (i % 3 == 1)
        ? instr_pkg::OP_READ_CONTROL_PORT : instr_pkg::OP_READ_EXTENDED_PORT;
      run(op | {6'h00, b[1:0]}, b, 8'h00);
      cmp({reg_wr_en, reg_wr_sel, reg_wr_data}, {1'b1, b[1:0], a});
      cmp(lower_status_byte[7:6], scc(a));
      cmp({port_read, port_ext, cycles_used}, {1'b1, i % 3 == 2, 3'h2 + 3'(i % 3 == 2)});
      if (i % 3 == 2) cmp(port_addr, b);
      else cmp(port_is_data, i % 3 == 0);
    end
    present = 1'b0;
    for (int k = 0; k < 2; k++) begin
      rnd(a);
      rnd(b);
      reg_sel_val = a;
      lo = lower_status_byte;
      run((k ? instr_pkg::OP_WRITE_EXTENDED_PORT : instr_pkg::OP_WRITE_DATA_PORT) | {6'h00, b[1:0]}, b, 8'h00);
      cmp({port_write, bus_data_out}, {1'b1, a});
      cmp(lower_status_byte[7:6], lo[7:6]);
      if (k) cmp({port_addr, cycles_used}, {b, 3'h3});
    end
    run(instr_pkg::OP_PPSU, 8'h20, 8'h00);
    cmp(upper_status_byte[5], 1'b1);
    rnd(a);
    next_pc = {a[6:0], 8'h21};
    run(instr_pkg::OP_ZCALL, 8'h85, 8'h00);
    cmp({jump_addr, bytes_used, cycles_used}, {15'h0005, 5'h15});
    next_pc = 15'h1234;
    reg_r3 = 8'h04;
    run(instr_pkg::OP_XCALL, 8'h12, 8'h30);
    cmp({jump_valid, bytes_used, cycles_used}, {1'b1, 5'h1b});
    cmp(jump_addr, 15'h1234);
    run(instr_pkg::OP_RET | 8'h03, 8'h00, 8'h00);
    cmp({jump_addr, bytes_used, cycles_used}, {15'h1234, 5'h0b});
    run(instr_pkg::OP_CPSL, 8'hc0, 8'h00);
    run(instr_pkg::OP_PPSL, 8'h40, 8'h00);
    run(instr_pkg::OP_RETE | 8'h01, 8'h00, 8'h00);
    cmp({jump_addr, upper_status_byte[5]}, {a[6:0], 8'h21, 1'b0});
    enhanced_variant = 1'b1;
    present = 1'b1;
    rnd(a);
    value = a;
    run(instr_pkg::OP_LOAD_LOWER_STATUS_FROM_MEMORY, 8'h81, 8'h00);
    cmp({lower_status_byte, bytes_used, cycles_used}, {a, 5'h1e});
    run(instr_pkg::OP_STORE_LOWER_STATUS_TO_MEMORY, 8'h01, 8'h40);
    cmp({mem_write, bus_data_out, cycles_used}, {1'b1, a, 3'h4});
    cmp(mem_addr, 15'h0140);
    for (int k = 0; k < 2; k++) begin
      enhanced_variant = k[0];
      rnd(a);
      reg_r0 = a & 8'hdf;
      run(instr_pkg::OP_LPSU, 8'h00, 8'h00);
      cmp(upper_status_byte & 8'h3f, reg_r0 & (k ? 8'h3f : 8'h27));
    end
    run(instr_pkg::OP_HALT, 8'h00, 8'h00);
    cmp({halted, bytes_used, cycles_used}, {1'b1, 5'h09});
    rnd(a);
    value = a;
    int_request = 1'b1;
    for (int n = 0; n < 40 && interrupt_acknowledge !== 1'b1; n++)
      @(posedge sys_clk) #1;
    int_request = 1'b0;
    cmp({interrupt_acknowledge, upper_status_byte[5], jump_addr}, {2'h3, 8'h00, a[6:0]});
    for (int n = 0; n < 40 && busy === 1'b1; n++) @(posedge sys_clk) #1;
    cmp(halted, 1'b0);
    conclude();
  end
endmodule
